// File: core/dtc_half.sv
// One timer half: gating of counting, capture edge detection, trigger and PWM outputs.
// Assumes pin inputs are already synchronised by the top; debug_halt comes from aclk logic.
`timescale 1ns/1ns
`default_nettype none
module dtc_half (
  input  wire logic  aclk,
  input  wire logic  aresetn,
  input  wire logic  clk_en,
  dtc_half_if.half   ctl,
  input  wire logic  debug_halt,
  input  wire logic  cap_prev,
  input  wire logic  cap_now,
  input  wire logic  trig_raw,
  input  wire logic  pwm_raw,
  output wire logic  count_en,
  output logic       capture_event,
  output logic       adc_trigger,
  output logic       pwm_out
);

  wire rise_w = cap_now & ~cap_prev;
  wire fall_w = ~cap_now & cap_prev;
  logic edge_hit;

  // Reserved encoding behaves as rising edge
  always_comb begin
    case (ctl.edge_sel)
      dtc_pkg::DTC_EDGE_FALL: edge_hit = fall_w;
      dtc_pkg::DTC_EDGE_BOTH: edge_hit = rise_w | fall_w;
      default:                edge_hit = rise_w;
    endcase
  end

  assign count_en = ctl.enable & ~(ctl.freeze & debug_halt);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_event <= 1'b0;
      adc_trigger   <= 1'b0;
      pwm_out       <= 1'b0;
    end else if (clk_en) begin
      capture_event <= edge_hit & count_en;
      adc_trigger   <= trig_raw & ctl.trig_en & ctl.enable;
      pwm_out       <= pwm_raw ^ ctl.pwm_inv;
    end
  end

endmodule : dtc_half
`default_nettype wire

// File: core/dtc_half_if.sv
// Interface carrying one timer half's decoded control from the register file to its logic.
// Assumes both ends share aclk.
`timescale 1ns/1ns
`default_nettype none
interface dtc_half_if;
  logic             enable;
  logic             freeze;
  logic [1:0]       edge_sel;
  logic             trig_en;
  logic             pwm_inv;
  modport ctrl (output enable, output freeze, output edge_sel, output trig_en, output pwm_inv);
  modport half (input enable, input freeze, input edge_sel, input trig_en, input pwm_inv);
endinterface : dtc_half_if
`default_nettype wire

// File: core/dtc_pkg.sv
// Package for the dual timer control block: register map, field layout, reset values.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package dtc_pkg;

  localparam logic [11:0] DTC_CTRL_OFFSET  = 12'h00C;
  localparam logic [31:0] DTC_CTRL_RESET   = 32'h00000000;
  localparam logic [31:0] DTC_CTRL_WMASK   = 32'h00006F7F;

  localparam int DTC_A_EN_BIT      = 0;
  localparam int DTC_A_FREEZE_BIT  = 1;
  localparam int DTC_A_EDGE_LSB    = 2;
  localparam int DTC_RTC_EN_BIT    = 4;
  localparam int DTC_A_TRIG_BIT    = 5;
  localparam int DTC_A_INV_BIT     = 6;
  localparam int DTC_B_EN_BIT      = 8;
  localparam int DTC_B_FREEZE_BIT  = 9;
  localparam int DTC_B_EDGE_LSB    = 10;
  localparam int DTC_B_TRIG_BIT    = 13;
  localparam int DTC_B_INV_BIT     = 14;

  localparam logic [1:0] DTC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] DTC_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    DTC_EDGE_RISE = 2'h0,
    DTC_EDGE_FALL = 2'h1,
    DTC_EDGE_RSVD = 2'h2,
    DTC_EDGE_BOTH = 2'h3
  } dtc_edge_t;

endpackage : dtc_pkg

// File: core/dtc_top.sv
// Dual timer control register and the per-half control it steers.
// Assumes an AXI4-Lite master on aclk; capture pins are asynchronous to aclk.
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// [R1] Half B ADC trigger driven only while its trigger enable bit is set.
// [R2] Converter must be enabled and select this timer to start conversions.
// [R3] Half B edge field: 0 rising, 1 falling, 3 both, 2 reserved.
// [R4] Half B freeze bit stops its count while debug-halted.
// [R5] Half A freeze bit stops its count while debug-halted.
// [R6] Freeze bits have no effect when processor runs normally.
// [R7] Half B enable bit starts counting or capture; clear disables.
// [R8] Half A PWM invert bit inverts its PWM output.
// [R9] Half A ADC trigger driven only while its trigger enable bit is set.
// [R10] Clock-calendar enable bit starts real-time counting; clear stops it.
// [R11] Half A edge field: 0 rising, 1 falling, 3 both, 2 reserved.
// [R12] Half A enable bit starts counting or capture; clear disables.
// [R13] Software preserves reserved bits on read-modify-write.
// [R14] Software never writes reserved edge encoding.
module dtc_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        debug_halt,
  input  wire logic        cap_a_pin,
  input  wire logic        cap_b_pin,
  input  wire logic        trig_a_raw,
  input  wire logic        trig_b_raw,
  input  wire logic        pwm_a_raw,
  input  wire logic        pwm_b_raw,
  input  wire logic        rtc_tick,
  output wire logic        count_en_a,
  output wire logic        count_en_b,
  output wire logic        capture_a,
  output wire logic        capture_b,
  output wire logic        adc_trigger_a,
  output wire logic        adc_trigger_b,
  output wire logic        pwm_a_out,
  output wire logic        pwm_b_out,
  output logic             rtc_running,
  output logic [31:0]      rtc_count
);

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic [31:0] timer_control_reg;
  logic [31:0] timer_control_next;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  // Address and data are latched separately so either may arrive first
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [11:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;

  // Responses and readies are hidden while clk_en is low, so no handshake can
  // complete on a cycle whose frozen state would not record it
  logic        b_valid_reg;
  logic        r_valid_reg;

  assign s_axi_bvalid  = b_valid_reg & clk_en;
  assign s_axi_rvalid  = r_valid_reg & clk_en;
  assign s_axi_awready = ~aw_held_reg & ~b_valid_reg & clk_en;
  assign s_axi_wready  = ~w_held_reg & ~b_valid_reg & clk_en;

  wire        aw_take  = s_axi_awvalid & s_axi_awready;
  wire        w_take   = s_axi_wvalid & s_axi_wready;
  wire        aw_have  = aw_held_reg | aw_take;
  wire        w_have   = w_held_reg | w_take;
  wire        wr_fire  = aw_have & w_have & clk_en;
  wire [11:0] wr_addr  = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
  wire [31:0] wr_data  = w_held_reg ? w_data_reg : s_axi_wdata;
  wire [3:0]  wr_strb  = w_held_reg ? w_strb_reg : s_axi_wstrb;
  wire        wr_hit   = (wr_addr[11:2] == dtc_pkg::DTC_CTRL_OFFSET[11:2]);

  function automatic logic [31:0] dtc_strb_mask(input logic [3:0] strb);
    dtc_strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : dtc_strb_mask

  wire [31:0] wr_mask = dtc_strb_mask(wr_strb) & dtc_pkg::DTC_CTRL_WMASK;

  // Reserved bits never store, so they always read zero
  always_comb begin
    timer_control_next = timer_control_reg;
    if (wr_fire && wr_hit) begin
      timer_control_next = (timer_control_reg & ~wr_mask) | (wr_data & wr_mask);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
    end else if (clk_en) begin
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
      end else begin
        if (aw_take) begin
          aw_held_reg <= 1'b1;
          aw_addr_reg <= s_axi_awaddr;
        end
        if (w_take) begin
          w_held_reg <= 1'b1;
          w_data_reg <= s_axi_wdata;
          w_strb_reg <= s_axi_wstrb;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      b_valid_reg <= 1'b0;
      s_axi_bresp <= dtc_pkg::DTC_RESP_OKAY;
    end else if (clk_en) begin
      if (wr_fire) begin
        b_valid_reg <= 1'b1;
        s_axi_bresp <= wr_hit ? dtc_pkg::DTC_RESP_OKAY : dtc_pkg::DTC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        b_valid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_control_reg <= dtc_pkg::DTC_CTRL_RESET;
    end else if (clk_en) begin
      timer_control_reg <= timer_control_next;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = ~r_valid_reg & clk_en;
  wire rd_take = s_axi_arvalid & s_axi_arready & clk_en;
  wire rd_hit  = (s_axi_araddr[11:2] == dtc_pkg::DTC_CTRL_OFFSET[11:2]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_valid_reg  <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= dtc_pkg::DTC_RESP_OKAY;
    end else if (clk_en) begin
      if (rd_take) begin
        r_valid_reg  <= 1'b1;
        s_axi_rdata  <= rd_hit ? timer_control_reg : 32'h00000000;
        s_axi_rresp  <= rd_hit ? dtc_pkg::DTC_RESP_OKAY : dtc_pkg::DTC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        r_valid_reg  <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Capture pin synchronisers
  // ----------------------------------------------------------------
  // Edges are judged on stages two and three so stage one stays isolated
  logic [2:0] cap_a_sync_reg;
  logic [2:0] cap_b_sync_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_a_sync_reg <= 3'h0;
      cap_b_sync_reg <= 3'h0;
    end else if (clk_en) begin
      cap_a_sync_reg <= {cap_a_sync_reg[1:0], cap_a_pin};
      cap_b_sync_reg <= {cap_b_sync_reg[1:0], cap_b_pin};
    end
  end

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  dtc_half_if half_a_ctl ();
  dtc_half_if half_b_ctl ();

  assign half_a_ctl.enable   = timer_control_reg[dtc_pkg::DTC_A_EN_BIT];        // [R12]
  assign half_a_ctl.freeze   = timer_control_reg[dtc_pkg::DTC_A_FREEZE_BIT];    // [R5]
  assign half_a_ctl.edge_sel = timer_control_reg[dtc_pkg::DTC_A_EDGE_LSB +: 2]; // [R11]
  assign half_a_ctl.trig_en  = timer_control_reg[dtc_pkg::DTC_A_TRIG_BIT];      // [R9]
  assign half_a_ctl.pwm_inv  = timer_control_reg[dtc_pkg::DTC_A_INV_BIT];       // [R8]

  assign half_b_ctl.enable   = timer_control_reg[dtc_pkg::DTC_B_EN_BIT];        // [R7]
  assign half_b_ctl.freeze   = timer_control_reg[dtc_pkg::DTC_B_FREEZE_BIT];    // [R4]
  assign half_b_ctl.edge_sel = timer_control_reg[dtc_pkg::DTC_B_EDGE_LSB +: 2]; // [R3]
  assign half_b_ctl.trig_en  = timer_control_reg[dtc_pkg::DTC_B_TRIG_BIT];      // [R1]
  assign half_b_ctl.pwm_inv  = timer_control_reg[dtc_pkg::DTC_B_INV_BIT];

  // ----------------------------------------------------------------
  // Timer halves
  // ----------------------------------------------------------------
  // Freeze only bites together with debug_halt, so normal running ignores it
  dtc_half u_half_a (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .clk_en        (clk_en),
    .ctl           (half_a_ctl.half),
    .debug_halt    (debug_halt),          // [R6]
    .cap_prev      (cap_a_sync_reg[2]),
    .cap_now       (cap_a_sync_reg[1]),
    .trig_raw      (trig_a_raw),
    .pwm_raw       (pwm_a_raw),
    .count_en      (count_en_a),
    .capture_event (capture_a),
    .adc_trigger   (adc_trigger_a),
    .pwm_out       (pwm_a_out)
  );

  dtc_half u_half_b (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .clk_en        (clk_en),
    .ctl           (half_b_ctl.half),
    .debug_halt    (debug_halt),          // [R6]
    .cap_prev      (cap_b_sync_reg[2]),
    .cap_now       (cap_b_sync_reg[1]),
    .trig_raw      (trig_b_raw),
    .pwm_raw       (pwm_b_raw),
    .count_en      (count_en_b),
    .capture_event (capture_b),
    .adc_trigger   (adc_trigger_b),
    .pwm_out       (pwm_b_out)
  );

  // ----------------------------------------------------------------
  // Clock-calendar counter
  // ----------------------------------------------------------------
  // Counts rtc_tick pulses; a stall during debug halt follows half A's freeze
  wire rtc_en_w = timer_control_reg[dtc_pkg::DTC_RTC_EN_BIT];                    // [R10]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rtc_running <= 1'b0;
      rtc_count   <= 32'h00000000;
    end else if (clk_en) begin
      rtc_running <= rtc_en_w;
      if (rtc_en_w && rtc_tick && !(half_a_ctl.freeze && debug_halt)) begin  // [R10]
        rtc_count <= rtc_count + 32'h00000001;
      end
    end
  end

endmodule : dtc_top
`default_nettype wire

// File: test/dtc_adc_model.sv
// Converter model: counts conversion starts from the timer triggers.
// Assumes the triggers are levels on aclk.
`timescale 1ns/1ns
`default_nettype none
module dtc_adc_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       conv_on,
  input  wire logic       src_b,
  input  wire logic       adc_trigger_a,
  input  wire logic       adc_trigger_b,
  output var  logic [7:0] starts
);
  logic sel_q;
  wire  logic sel = src_b ? adc_trigger_b : adc_trigger_a;
  // Only a converter that is on and has this half as its source starts
  always_ff @(posedge aclk) begin
    sel_q <= sel;
    if (!aresetn)
      starts <= 8'h00;
    else if (conv_on && sel && !sel_q)
      starts <= starts + 8'h01;
  end
endmodule : dtc_adc_model
`default_nettype wire

// File: test/dtc_top_sva.sv
// Checker for dtc_top: control field effects seen at the ports.
// Assumes clk_en stays high; bound into dtc_top below.
`timescale 1ns/1ns
`default_nettype none
module dtc_top_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        debug_halt,
  input wire logic        trig_a_raw,
  input wire logic        trig_b_raw,
  input wire logic        rtc_tick,
  input wire logic        count_en_a,
  input wire logic        count_en_b,
  input wire logic        capture_b,
  input wire logic        adc_trigger_a,
  input wire logic        adc_trigger_b,
  input wire logic        rtc_running,
  input wire logic [31:0] rtc_count
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A write lands the cycle bvalid rises, so halt edges then are skipped
  a_trig_a_gate: assert property (adc_trigger_a |-> $past(trig_a_raw))
    else $error("stray trigger a");
  a_trig_b_gate: assert property (adc_trigger_b |-> $past(trig_b_raw))
    else $error("stray trigger b");
  a_halt_stop_a: assert property ($rose(debug_halt) && !$rose(s_axi_bvalid)
    |-> count_en_a <= $past(count_en_a)) else $error("a started on halt");
  a_halt_stop_b: assert property ($rose(debug_halt) && !$rose(s_axi_bvalid)
    |-> count_en_b <= $past(count_en_b)) else $error("b started on halt");
  a_run_resume: assert property ($fell(debug_halt) && !$rose(s_axi_bvalid)
    |-> count_en_a >= $past(count_en_a)) else $error("a stopped on resume");
  a_rtc_step: assert property (rtc_running && $past(rtc_running) && $past(rtc_tick)
    && !$past(debug_halt) |-> rtc_count == $past(rtc_count) + 32'h1)
    else $error("rtc tick missed");
  a_rtc_hold: assert property (!rtc_running && !$past(rtc_running)
    |-> $stable(rtc_count)) else $error("rtc moved while off");
  a_cap_b_gate: assert property (capture_b |-> $past(count_en_b))
    else $error("capture b while off");
  c_trig_b: cover property (adc_trigger_b);
  c_halt_b: cover property ($rose(debug_halt) && count_en_b);
  c_rtc: cover property (rtc_running && rtc_tick);
endmodule : dtc_top_sva
bind dtc_top dtc_top_sva dtc_top_sva_inst (.aclk, .aresetn, .s_axi_bvalid, .debug_halt,
  .trig_a_raw, .trig_b_raw, .rtc_tick, .count_en_a, .count_en_b, .capture_b,
  .adc_trigger_a, .adc_trigger_b, .rtc_running, .rtc_count);
`default_nettype wire

// File: test/tb.sv
// Testbench for dtc_top: register access and the effect of each field.
// Assumes dtc_top is an AXI4-Lite slave on aclk.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        aclk, aresetn, debug_halt, rtc_tick, conv_on, src_b, rtc_running;
  logic        trig_a_raw, trig_b_raw, pwm_a_raw, count_en_a, count_en_b, capture_a;
  logic        capture_b, adc_trigger_a, adc_trigger_b, pwm_a_out, pwm_b_out;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rtc_count, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs, cap;
  logic [7:0]  starts;
  int          failures, n_tests, cyc, nc [2];

  dtc_top dtc_top_inst (.aclk, .aresetn, .clk_en(1'b1), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .debug_halt, .cap_a_pin(cap[0]), .cap_b_pin(cap[1]), .trig_a_raw, .trig_b_raw,
    .pwm_a_raw, .pwm_b_raw(1'b0), .rtc_tick, .count_en_a, .count_en_b, .capture_a,
    .capture_b, .adc_trigger_a, .adc_trigger_b, .pwm_a_out, .pwm_b_out, .rtc_running,
    .rtc_count);
  dtc_adc_model dtc_adc_model_inst (.aclk, .aresetn, .conv_on, .src_b, .adc_trigger_a,
    .adc_trigger_b, .starts);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Capture pulses are counted here, as they last only one cycle
  always @(posedge aclk) begin
    if (capture_a === 1'b1) nc[0]++;
    if (capture_b === 1'b1) nc[1]++;
    cyc++;
    if (cyc == 5000) begin
      failures++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [31:0] d, input logic [11:0] a = dtc_pkg::DTC_CTRL_OFFSET);
    logic aw_d = 1'b0;
    logic w_d = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(aw_d && w_d)) begin
      @(posedge aclk);
      aw_d |= s_axi_awready === 1'b1;
      w_d |= s_axi_wready === 1'b1;
      s_axi_awvalid <= !aw_d;
      s_axi_wvalid <= !w_d;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd_reg(input logic [11:0] a = dtc_pkg::DTC_CTRL_OFFSET);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd_reg
  // One rising then one falling pin edge on half h, captures counted for each
  task automatic edge_chk(input int h, input logic [1:0] code, input logic en);
    int n0;
    wr({28'h0, code, 1'b0, en} << (8 * h));
    n0 = nc[h];
    cap[h] <= 1'b1;
    repeat (8) @(posedge aclk);
    chk(32'(nc[h] - n0), {31'h0, en && code != 2'h1});
    n0 = nc[h];
    cap[h] <= 1'b0;
    repeat (8) @(posedge aclk);
    chk(32'(nc[h] - n0), {31'h0, en && code[0]});
  endtask : edge_chk
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  initial begin
    {aresetn, debug_halt, rtc_tick, conv_on, src_b, trig_a_raw, trig_b_raw, pwm_a_raw} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, cap} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {failures, n_tests, cyc, nc[0], nc[1]} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg();
    chk(rd, dtc_pkg::DTC_CTRL_RESET);
    wr(32'hFFFF_FFFF);
    rd_reg();
    chk(rd, dtc_pkg::DTC_CTRL_WMASK);
    wr(32'h0, 12'h010);
    chk({30'h0, rs}, {30'h0, dtc_pkg::DTC_RESP_SLVERR});
    rd_reg(12'h010);
    chk({rs, rd[29:0]}, {dtc_pkg::DTC_RESP_SLVERR, 30'h0});
    $display("test registers done");
    for (int f = 0; f < 4; f++) begin
      wr(32'h101 | {22'h0, f[1], 7'h0, f[0], 1'b0});
      debug_halt <= 1'b1;
      @(posedge aclk);
      chk({count_en_b, count_en_a}, {30'h0, ~f[1], ~f[0]});
      debug_halt <= 1'b0;
      @(posedge aclk);
      chk({count_en_b, count_en_a}, 32'h3);
    end
    $display("test freeze done");
    conv_on <= 1'b1;
    for (int t = 0; t < 2; t++) begin
      wr(32'h101 | {18'h0, t[0], 7'h0, t[0], 5'h0});
      {trig_a_raw, trig_b_raw} <= 2'h3;
      repeat (2) @(posedge aclk);
      chk({adc_trigger_b, adc_trigger_a}, {30'h0, t[0], t[0]});
      {trig_a_raw, trig_b_raw} <= 2'h0;
    end
    // Half B raw PWM is tied low, so its output shows its invert bit alone
    pwm_a_raw <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      wr({17'h0, i[0], 7'h0, i[0], 6'h0});
      repeat (2) @(posedge aclk);
      chk({pwm_b_out, pwm_a_out}, {30'h0, i[0], ~i[0]});
    end
    chk(starts, 8'h01);
    $display("test trigger and pwm done");
    wr(32'h10);
    repeat (3) begin
      rtc_tick <= 1'b1;
      @(posedge aclk);
      rtc_tick <= 1'b0;
      @(posedge aclk);
    end
    @(posedge aclk);
    chk(rtc_count, 32'h3);
    wr(32'h0);
    rtc_tick <= 1'b1;
    @(posedge aclk);
    rtc_tick <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(rtc_count, 32'h3);
    $display("test clock calendar done");
    for (int h = 0; h < 2; h++) begin
      // Software never writes the reserved edge code
      for (int c = 0; c < 4; c++)
        if (c != 2) edge_chk(h, c[1:0], 1'b1);
      edge_chk(h, 2'h3, 1'b0);
    end
    $display("test edges done");
    complete_run();
  end
endmodule : tb
`default_nettype wire
